//--- rpd_pkg.sv
// Purpose: constants for the reset and power-down controller
// Assumes: 4-bit core registers, one 40 MHz clock
// Notes: register map is reached over APB, one word per register
package rpd_pkg;
  localparam logic [7:0] RPD_CTRL_OFS = 8'h00;
  localparam logic [7:0] RPD_STAT_OFS = 8'h04;
  localparam logic [7:0] RPD_CFG_OFS = 8'h08;
  localparam logic [7:0] RPD_PC_OFS = 8'h0C;
  // control word bit positions (write strobes)
  localparam int RPD_CMD_ARM = 0;
  localparam int RPD_CMD_PDEN = 1;
  localparam int RPD_CMD_POFC = 2;
  localparam int RPD_CMD_POFR = 3;
  localparam int RPD_CMD_SWRST = 4;
  localparam int RPD_CMD_IE_SET = 5;
  // core flag stand-ins, so reset clearing them can be observed
  localparam int RPD_CMD_CY_SET = 6;
  localparam int RPD_CMD_UP_SET = 7;
  // reset values
  localparam logic [3:0] RPD_NIB_RST = 4'h0;
  localparam logic [13:0] RPD_PC_RST = 14'h0000;
  // reset pulse length in cycles
  localparam int RPD_RST_CYC = 4;
  typedef enum logic [2:0] {
    RPD_RUN = 3'b001,
    RPD_CLKM = 3'b010,
    RPD_RAMB = 3'b100
  } rpd_state_e;
endpackage

//--- rpd_top.sv
// Purpose: reset and power-down sequencer of a 4-bit core
// Assumes: instruction strobes are one-cycle pulses, inputs synchronous
// Notes: also controllable by APB for test and configuration
// Function
// - any reset loads program counter zero
// - reset clears global interrupt enable
// - reset stops timer prescaler
// - reset zeroes display, wakeup, pullup, port registers
// - reset clears carry and upper-bit reference flags
// - supply drop forces system reset
// - arm instruction keeps drop detection in powerdown
// - arm instruction acts only once
// - arm latch cleared only by reset
// - enable then first off enters clock mode
// - enable then second off enters RAM backup
// - off without enable acts as no-op
// - clock mode keeps RAM, subclock, LCD, timer3
// - RAM backup keeps only RAM and reset
// - wake on external signal or timer3 underflow
// - warm start: PC zero, warm flag one
// - cold start: PC zero, warm flag zero
// - software tests warm flag and timer3 flag
// - only external wakeup or a cold reset ends RAM backup
`timescale 1ns/1ps
module rpd_top
  import rpd_pkg::*;
#(
  parameter int RST_CYC = RPD_RST_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_n,
  input wire logic watchdog_rst,
  input wire logic supply_drop,
  input wire logic arm_drop_detect_instr,
  input wire logic powerdown_enable_instr,
  input wire logic clock_mode_off_instr,
  input wire logic ram_backup_off_instr,
  input wire logic ext_wakeup,
  input wire logic timer3_underflow,
  input wire logic skip_if_warm_instr,
  output logic skip_taken,
  output logic core_reset,
  output logic pc_load,
  output logic [13:0] pc_value,
  output logic global_irq_enable,
  output logic carry_flag,
  output logic upper_bit_ref_enable,
  output logic [3:0] prescaler_control,
  output logic [3:0] display_ctrl_second,
  output logic [3:0] wakeup_ctrl_first,
  output logic [3:0] pullup_ctrl_first,
  output logic [3:0] pullup_ctrl_second,
  output logic [3:0] port_structure_first,
  output logic [3:0] port_structure_second,
  output logic [3:0] port_structure_third,
  output logic timer3_request_flag,
  output logic warm_flag,
  output logic drop_detect_active,
  output logic main_osc_run,
  output logic subclock_run,
  output logic lcd_run,
  output logic timer3_run,
  output logic cpu_clk_run
);
  // elaboration check: the restart counter is 8 bits and must run once
  if (RST_CYC < 1 || RST_CYC > 255) begin : g_bad_rst_cyc
    $error("rpd_top: RST_CYC out of range");
  end

  // any cold source; the drop input only counts while detection runs
  function automatic logic is_cold(input logic pin_n, input logic wd,
                                   input logic drop, input logic det_on,
                                   input logic sw);
    is_cold = !pin_n || wd || (drop && det_on) || sw;
  endfunction

  rpd_state_e st_ff, nxt_st;
  logic arm_ff, nxt_arm;
  logic pden_ff, nxt_pden;
  logic warm_ff, nxt_warm;
  logic t3req_ff, nxt_t3req;
  logic ie_ff, nxt_ie;
  logic carry_ff, nxt_carry;
  logic up_ff, nxt_up;
  logic [3:0] presc_ff, nxt_presc;
  logic [3:0] disp2_ff, nxt_disp2;
  logic [3:0] wake1_ff, nxt_wake1;
  logic [3:0] pull1_ff, nxt_pull1;
  logic [3:0] pull2_ff, nxt_pull2;
  logic [3:0] pstr1_ff, nxt_pstr1;
  logic [3:0] pstr2_ff, nxt_pstr2;
  logic [3:0] pstr3_ff, nxt_pstr3;
  logic [7:0] rcnt_ff, nxt_rcnt;
  logic pcld_ff, nxt_pcld;
  logic skip_ff, nxt_skip;
  logic [31:0] rd_ff, nxt_rd;

  logic det_on, cold, wake, acc, wr, rd_ok;
  logic cmd_arm, cmd_pden, cmd_pofc, cmd_pofr, cmd_sw;

  // apb decode; writes to the control word act as instruction strobes
  always_comb begin
    acc = psel && penable;
    wr = acc && pwrite && paddr == RPD_CTRL_OFS;
    cmd_arm = arm_drop_detect_instr || (wr && pwdata[RPD_CMD_ARM]);
    cmd_pden = powerdown_enable_instr || (wr && pwdata[RPD_CMD_PDEN]);
    cmd_pofc = clock_mode_off_instr || (wr && pwdata[RPD_CMD_POFC]);
    cmd_pofr = ram_backup_off_instr || (wr && pwdata[RPD_CMD_POFR]);
    cmd_sw = wr && pwdata[RPD_CMD_SWRST];
  end

  // detection runs while awake, or in powerdown only once armed
  always_comb begin
    det_on = (st_ff == RPD_RUN) || arm_ff;
    cold = is_cold(reset_pin_n, watchdog_rst, supply_drop, det_on,
                   cmd_sw);
    // backup mode has no clock source, so timer 3 cannot wake it
    wake = ext_wakeup || (st_ff == RPD_CLKM && timer3_underflow);
  end

  // sequencer and flags
  always_comb begin
    nxt_st = st_ff;
    nxt_arm = arm_ff;
    nxt_pden = pden_ff;
    nxt_warm = warm_ff;
    nxt_t3req = t3req_ff;
    nxt_ie = ie_ff;
    nxt_carry = carry_ff;
    nxt_up = up_ff;
    nxt_presc = presc_ff;
    nxt_disp2 = disp2_ff;
    nxt_wake1 = wake1_ff;
    nxt_pull1 = pull1_ff;
    nxt_pull2 = pull2_ff;
    nxt_pstr1 = pstr1_ff;
    nxt_pstr2 = pstr2_ff;
    nxt_pstr3 = pstr3_ff;
    nxt_pcld = 1'b0;
    nxt_rcnt = (rcnt_ff != 8'h00) ? rcnt_ff - 8'h01 : 8'h00;
    nxt_skip = skip_if_warm_instr && warm_ff;
    // timer 3 stands still in backup mode, so no flag there
    if (timer3_underflow && st_ff != RPD_RAMB) begin
      nxt_t3req = 1'b1;
    end
    if (cold) begin
      // cold start: whole defined state reloaded
      nxt_st = RPD_RUN;
      nxt_arm = 1'b0;
      nxt_pden = 1'b0;
      nxt_warm = 1'b0;
      nxt_t3req = 1'b0;
      nxt_ie = 1'b0;
      nxt_carry = 1'b0;
      nxt_up = 1'b0;
      nxt_presc = RPD_NIB_RST;
      nxt_disp2 = RPD_NIB_RST;
      nxt_wake1 = RPD_NIB_RST;
      nxt_pull1 = RPD_NIB_RST;
      nxt_pull2 = RPD_NIB_RST;
      nxt_pstr1 = RPD_NIB_RST;
      nxt_pstr2 = RPD_NIB_RST;
      nxt_pstr3 = RPD_NIB_RST;
      nxt_rcnt = 8'(RST_CYC);
      nxt_pcld = 1'b1;
      nxt_skip = 1'b0;
    end else begin
      unique case (st_ff)
        RPD_RUN: begin
          // the latch ignores repeats; only a cold start drops it
          if (cmd_arm && !arm_ff) begin
            nxt_arm = 1'b1;
          end
          if (cmd_pofc && pden_ff) begin
            nxt_st = RPD_CLKM;
            nxt_warm = 1'b1;
            nxt_pden = 1'b0;
          end else if (cmd_pofr && pden_ff) begin
            nxt_st = RPD_RAMB;
            nxt_warm = 1'b1;
            nxt_pden = 1'b0;
          end else if (cmd_pden) begin
            nxt_pden = 1'b1;
          end else if (cmd_pofc || cmd_pofr) begin
            nxt_pden = 1'b0;
          end
          // core flag stand-ins, settable only while running
          if (wr && pwdata[RPD_CMD_IE_SET]) begin
            nxt_ie = 1'b1;
          end
          if (wr && pwdata[RPD_CMD_CY_SET]) begin
            nxt_carry = 1'b1;
          end
          if (wr && pwdata[RPD_CMD_UP_SET]) begin
            nxt_up = 1'b1;
          end
        end
        RPD_CLKM, RPD_RAMB: begin
          if (wake) begin
            // warm start keeps registers but clears interrupt enable, carry and prescaler, restarts at page 0
            nxt_st = RPD_RUN;
            nxt_ie = 1'b0;
            nxt_carry = 1'b0;
            nxt_presc = RPD_NIB_RST;
            nxt_pcld = 1'b1;
            nxt_rcnt = 8'(RST_CYC);
          end
        end
        default: nxt_st = RPD_RUN;
      endcase
    end
    // config register write, only while running
    if (acc && pwrite && paddr == RPD_CFG_OFS && !cold &&
        st_ff == RPD_RUN) begin
      nxt_disp2 = pwdata[3:0];
      nxt_wake1 = pwdata[7:4];
      nxt_pull1 = pwdata[11:8];
      nxt_pull2 = pwdata[15:12];
      nxt_pstr1 = pwdata[19:16];
      nxt_pstr2 = pwdata[23:20];
      nxt_pstr3 = pwdata[27:24];
      nxt_presc = pwdata[31:28];
    end
    // status read clears timer flag; a new underflow wins
    if (acc && !pwrite && paddr == RPD_STAT_OFS && !cold &&
        !timer3_underflow) begin
      nxt_t3req = 1'b0;
    end
  end

  // register read mux; data is caught in the setup cycle so that it
  // already stands from flip-flops during the access cycle
  always_comb begin
    rd_ok = paddr == RPD_CTRL_OFS || paddr == RPD_STAT_OFS ||
            paddr == RPD_CFG_OFS || paddr == RPD_PC_OFS;
    nxt_rd = rd_ff;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        RPD_CTRL_OFS: nxt_rd = {26'h0, ie_ff, 3'h0, pden_ff, arm_ff};
        RPD_STAT_OFS: nxt_rd = {24'h0, det_on, up_ff, carry_ff, t3req_ff,
                                warm_ff, st_ff};
        RPD_CFG_OFS: nxt_rd = {presc_ff, pstr3_ff, pstr2_ff, pstr1_ff,
                               pull2_ff, pull1_ff, wake1_ff, disp2_ff};
        RPD_PC_OFS: nxt_rd = {18'h0, RPD_PC_RST};
        default: nxt_rd = 32'h0000_0000;
      endcase
    end
  end

  // state registers; presetn loads the cold-start values, but 1 instead of RST_CYC into the restart counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= RPD_RUN;
      arm_ff <= 1'b0;
      pden_ff <= 1'b0;
      warm_ff <= 1'b0;
      t3req_ff <= 1'b0;
      ie_ff <= 1'b0;
      carry_ff <= 1'b0;
      up_ff <= 1'b0;
      presc_ff <= RPD_NIB_RST;
      disp2_ff <= RPD_NIB_RST;
      wake1_ff <= RPD_NIB_RST;
      pull1_ff <= RPD_NIB_RST;
      pull2_ff <= RPD_NIB_RST;
      pstr1_ff <= RPD_NIB_RST;
      pstr2_ff <= RPD_NIB_RST;
      pstr3_ff <= RPD_NIB_RST;
      rcnt_ff <= 8'h01;
      pcld_ff <= 1'b1;
      skip_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
      arm_ff <= nxt_arm;
      pden_ff <= nxt_pden;
      warm_ff <= nxt_warm;
      t3req_ff <= nxt_t3req;
      ie_ff <= nxt_ie;
      carry_ff <= nxt_carry;
      up_ff <= nxt_up;
      presc_ff <= nxt_presc;
      disp2_ff <= nxt_disp2;
      wake1_ff <= nxt_wake1;
      pull1_ff <= nxt_pull1;
      pull2_ff <= nxt_pull2;
      pstr1_ff <= nxt_pstr1;
      pstr2_ff <= nxt_pstr2;
      pstr3_ff <= nxt_pstr3;
      rcnt_ff <= nxt_rcnt;
      pcld_ff <= nxt_pcld;
      skip_ff <= nxt_skip;
      rd_ff <= nxt_rd;
    end
  end

  // outputs; domain gating follows the power-down mode
  assign prdata = rd_ff;
  assign pready = 1'b1; // zero wait states
  assign pslverr = acc && !rd_ok;
  assign skip_taken = skip_ff;
  assign core_reset = rcnt_ff != 8'h00;
  assign pc_load = pcld_ff;
  assign pc_value = RPD_PC_RST;
  assign global_irq_enable = ie_ff;
  assign carry_flag = carry_ff;
  assign upper_bit_ref_enable = up_ff;
  assign prescaler_control = presc_ff;
  assign display_ctrl_second = disp2_ff;
  assign wakeup_ctrl_first = wake1_ff;
  assign pullup_ctrl_first = pull1_ff;
  assign pullup_ctrl_second = pull2_ff;
  assign port_structure_first = pstr1_ff;
  assign port_structure_second = pstr2_ff;
  assign port_structure_third = pstr3_ff;
  assign timer3_request_flag = t3req_ff;
  assign warm_flag = warm_ff;
  assign drop_detect_active = det_on;
  assign main_osc_run = st_ff == RPD_RUN;
  assign subclock_run = st_ff != RPD_RAMB;
  assign lcd_run = st_ff != RPD_RAMB;
  assign timer3_run = st_ff != RPD_RAMB;
  assign cpu_clk_run = st_ff == RPD_RUN;
endmodule

//--- rpd_monitor.sv
// Purpose: port checker for the reset and power-down sequencer
// Assumes: one clock domain, async active-low reset
// Notes: bound onto rpd_top from the bench top file
`timescale 1ns/1ps
module rpd_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic reset_pin_n,
  input wire logic watchdog_rst,
  input wire logic supply_drop,
  input wire logic ext_wakeup,
  input wire logic timer3_underflow,
  input wire logic skip_if_warm_instr,
  input wire logic skip_taken,
  input wire logic core_reset,
  input wire logic pc_load,
  input wire logic [13:0] pc_value,
  input wire logic global_irq_enable,
  input wire logic carry_flag,
  input wire logic upper_bit_ref_enable,
  input wire logic [3:0] display_ctrl_second,
  input wire logic [3:0] port_structure_third,
  input wire logic warm_flag,
  input wire logic drop_detect_active,
  input wire logic main_osc_run,
  input wire logic subclock_run,
  input wire logic lcd_run,
  input wire logic timer3_run,
  input wire logic cpu_clk_run
);
  // everything here lives on the single bus clock
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PC_ZERO: assert property (pc_load |-> pc_value == 14'h0000 &&
    core_reset)
    else $error("start without pc zero");
  AST_COLD_CLEAR: assert property (!reset_pin_n |=>
    !global_irq_enable && !carry_flag && !upper_bit_ref_enable &&
    display_ctrl_second == 4'h0 && port_structure_third == 4'h0)
    else $error("cold reset left state set");
  AST_DROP_RST: assert property (supply_drop && drop_detect_active
    |=> core_reset && !warm_flag) else $error("drop did not reset");
  AST_CLK_MODE: assert property (!cpu_clk_run && subclock_run
    |-> lcd_run && timer3_run && !main_osc_run)
    else $error("clock mode units wrong");
  AST_RAMB_MODE: assert property (!cpu_clk_run && !subclock_run
    |-> !main_osc_run && !lcd_run && !timer3_run)
    else $error("backup mode units wrong");
  AST_RAMB_HOLD: assert property (!cpu_clk_run && !subclock_run &&
    timer3_underflow && !ext_wakeup && reset_pin_n && !watchdog_rst &&
    !supply_drop && !psel |=> !cpu_clk_run)
    else $error("timer woke backup mode");
  AST_WARM_SET: assert property ($fell(cpu_clk_run) |-> warm_flag)
    else $error("power down without warm flag");
  AST_WAKE: assert property (!cpu_clk_run && (ext_wakeup ||
    timer3_underflow && subclock_run) |=> pc_load && warm_flag)
    else $error("wake did not warm start");
  AST_SKIP: assert property (skip_if_warm_instr
    |=> skip_taken == $past(warm_flag)) else $error("skip wrong");
endmodule

//--- rpd_decoder_model.sv
// Purpose: decoder stand-in issuing one-cycle instruction strobes
// Assumes: op is held with issue for exactly one cycle
// Notes: strobes are registered, so they trail a request by one edge
`timescale 1ns/1ps
module rpd_decoder_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic issue,
  input wire logic [2:0] op,
  output logic arm_drop_detect_instr,
  output logic powerdown_enable_instr,
  output logic clock_mode_off_instr,
  output logic ram_backup_off_instr,
  output logic skip_if_warm_instr
);
  logic [4:0] strobe_ff;
  // one strobe per op, never longer, like a real decode slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_ff <= 5'h00;
    end else begin
      strobe_ff <= issue ? (5'h01 << op) : 5'h00;
    end
  end
  assign {skip_if_warm_instr, ram_backup_off_instr, clock_mode_off_instr,
    powerdown_enable_instr, arm_drop_detect_instr} = strobe_ff;
endmodule

//--- tb_rpd_top.sv
// Purpose: directed bench for the reset and power-down sequencer
// Assumes: zero-wait APB, decoder strobes one cycle long
// Notes: restart length cut to 2 cycles to keep the run short
`timescale 1ns/1ps
module tb_rpd_top;
  import rpd_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, issue = 1'b0, slv;
  logic [2:0] op = 3'h0;
  logic [4:0] ev = 5'h00;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  wire supply_drop, watchdog_rst, ext_wakeup, timer3_underflow, reset_pin_n;
  logic pready, pslverr, skip_taken, core_reset, pc_load, carry_flag;
  logic arm_drop_detect_instr, powerdown_enable_instr, skip_if_warm_instr;
  logic clock_mode_off_instr, ram_backup_off_instr, global_irq_enable;
  logic upper_bit_ref_enable, timer3_request_flag, warm_flag, lcd_run;
  logic drop_detect_active, main_osc_run, subclock_run, timer3_run;
  logic cpu_clk_run;
  logic [13:0] pc_value;
  logic [3:0] prescaler_control, display_ctrl_second, wakeup_ctrl_first;
  logic [3:0] pullup_ctrl_first, pullup_ctrl_second, port_structure_first;
  logic [3:0] port_structure_second, port_structure_third;
  int err_total = 0, compares = 0;
  // event lines: reset pin is the only active-low one
  assign {timer3_underflow, ext_wakeup, watchdog_rst, supply_drop} = ev[3:0];
  assign reset_pin_n = !ev[4];
  rpd_top #(.RST_CYC(2)) rpd_top_i (.*);
  rpd_decoder_model rpd_decoder_model_i (.*);
  always #12.5 pclk = ~pclk;
  task automatic close_out();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // setup then access, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      err_total++;
      close_out();
    end
  endtask
  task automatic exec(input logic [2:0] c);
    @(posedge pclk);
    issue <= 1'b1;
    op <= c;
    @(posedge pclk);
    issue <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
  endtask
  // one-cycle event: 0 drop, 1 watchdog, 2 wakeup, 3 timer3, 4 pin
  task automatic poke(input int k);
    @(posedge pclk);
    ev <= 5'h01 << k;
    @(posedge pclk);
    ev <= 5'h00;
    @(negedge pclk);
  endtask
  task automatic settle();
    int n;
    n = 0;
    @(negedge pclk);
    while (core_reset !== 1'b0 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 40) begin
      err_total++;
      close_out();
    end
  endtask
  function automatic logic [31:0] nib();
    return {prescaler_control, display_ctrl_second, wakeup_ctrl_first,
      pullup_ctrl_first, pullup_ctrl_second, port_structure_first,
      port_structure_second, port_structure_third};
  endfunction
  // main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk(nib(), 32'h0);
    chk(32'({global_irq_enable, carry_flag, upper_bit_ref_enable,
      warm_flag, pc_value}), 32'h0);
    apb(1'b0, RPD_STAT_OFS, 32'h0);
    chk(rd, 32'h81);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(slv), 32'h1);
    apb(1'b1, RPD_CFG_OFS, 32'hFFFFFFFF);
    apb(1'b1, RPD_CTRL_OFS, 32'hE0);
    @(negedge pclk);
    chk(nib() & 32'(global_irq_enable), 32'h1);
    chk(nib(), 32'hFFFFFFFF);
    chk(32'({carry_flag, upper_bit_ref_enable}), 32'h3);
    poke(4);
    settle();
    chk(nib() | 32'(global_irq_enable), 32'h0);
    chk(32'({carry_flag, upper_bit_ref_enable}), 32'h0);
    exec(3'h2);
    chk(32'(cpu_clk_run), 32'h1);
    exec(3'h0);
    exec(3'h0);
    exec(3'h1);
    exec(3'h2);
    chk(32'({cpu_clk_run, subclock_run, lcd_run, main_osc_run,
      drop_detect_active, warm_flag}), 32'h1B);
    poke(3);
    settle();
    chk(32'({cpu_clk_run, warm_flag}), 32'h3);
    chk(32'(timer3_request_flag), 32'h1);
    exec(3'h4);
    chk(32'(skip_taken), 32'h1);
    apb(1'b0, RPD_STAT_OFS, 32'h0);
    chk(rd & 32'h1F, 32'h19);
    @(negedge pclk);
    chk(32'(timer3_request_flag), 32'h0);
    exec(3'h1);
    exec(3'h3);
    chk(32'({cpu_clk_run, subclock_run, main_osc_run,
      drop_detect_active}), 32'h1);
    poke(3);
    chk(32'(cpu_clk_run), 32'h0);
    poke(2);
    settle();
    chk(32'(cpu_clk_run), 32'h1);
    poke(0);
    settle();
    chk(32'(warm_flag), 32'h0);
    exec(3'h1);
    exec(3'h2);
    chk(32'(drop_detect_active), 32'h0);
    poke(2);
    settle();
    poke(1);
    settle();
    chk(32'({warm_flag, pc_value}), 32'h0);
    // same sequence through the control word instead of the decoder
    apb(1'b1, RPD_CTRL_OFS, 32'h03);
    apb(1'b0, RPD_CTRL_OFS, 32'h0);
    chk(rd, 32'h03);
    apb(1'b1, RPD_CTRL_OFS, 32'h04);
    @(negedge pclk);
    chk(32'({cpu_clk_run, drop_detect_active, warm_flag}), 32'h3);
    poke(2);
    settle();
    apb(1'b1, RPD_CTRL_OFS, 32'h10);
    settle();
    chk(32'(warm_flag), 32'h0);
    apb(1'b0, RPD_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, RPD_PC_OFS, 32'h0);
    chk(rd, 32'h0);
    close_out();
  end
endmodule
bind rpd_top rpd_monitor rpd_monitor_i (.*);
